// ### hw/acrl_pkg.sv
package acrl_pkg;
    localparam int CFG_W = 13;
    localparam int FRAME_BITS = 16;
    localparam int DATA_BITS = 12;
    localparam int ADDR_BITS = 4;
    localparam logic [4:0] CAPTURE_EDGES = 5'h0D;
    localparam logic [4:0] MUX_EDGE = 5'h0E;
    localparam logic [4:0] LAST_EDGE = 5'h10;
    localparam int BIT_WRITE = 12;
    localparam int BIT_SEQ = 11;
    localparam int BIT_ADDR_HI = 10;
    localparam int BIT_ADDR_LO = 7;
    localparam int BIT_PM_HI = 6;
    localparam int BIT_PM_LO = 5;
    localparam int BIT_SHADOW = 4;
    localparam int BIT_IDLE = 3;
    localparam int BIT_RANGE = 2;
    localparam int BIT_CODING = 1;
    localparam int BIT_INMODE = 0;
    localparam logic [11:0] CFG_RESET = 12'hFE3;
    localparam logic [15:0] SHADOW_RESET = 16'h0000;
    localparam int CLK_MHZ = 25;
    localparam int WAKEUP_NS = 1000;
    localparam int WAKEUP_CYC = (WAKEUP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0] PM_FULL = 2'h3;
    typedef struct packed {
        logic sequencer_enable;
        logic [3:0] channel_address;
        logic power_mode_hi;
        logic power_mode_lo;
        logic shadow_select;
        logic output_idle_select;
        logic range_select;
        logic coding_select;
        logic input_mode_select;
    } acrl_cfg_t;
    typedef struct packed {
        logic [3:0] channel;
        logic [11:0] data;
    } acrl_result_t;
    typedef enum logic [1:0] {
        ACRL_SEQ_OFF = 2'h0,
        ACRL_SEQ_SHADOW_LOAD = 2'h1,
        ACRL_SEQ_SHADOW_RUN = 2'h3,
        ACRL_SEQ_CONSEC = 2'h2
    } acrl_seq_t;
endpackage

// ### hw/acrl_sync.sv
`timescale 1ns/10ps
module acrl_sync (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic d,
    output logic q
);
    logic meta_reg;
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // idle high like select and serial clock, so no false edge follows reset
            meta_reg <= 1'b1;
            q <= 1'b1;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ### hw/acrl_buf2.sv
`timescale 1ns/10ps
module acrl_buf2 (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire acrl_pkg::acrl_result_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output acrl_pkg::acrl_result_t out_data
);
    acrl_pkg::acrl_result_t mem_reg [2];
    logic wr_reg;
    logic rd_reg;
    logic [1:0] cnt_reg;
    logic push;
    logic pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = cnt_reg != 2'h2;
    assign out_valid = cnt_reg != 2'h0;
    assign out_data = mem_reg[rd_reg];
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end
        else
        begin
            if (push)
                wr_reg <= ~wr_reg;
            if (pop)
                rd_reg <= ~rd_reg;
            cnt_reg <= 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
        end
    end
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_reg[wr_reg] <= in_data;
    end
endmodule

// ### hw/acrl_top.sv
`timescale 1ns/10ps
// Contract
// - write-only 13-bit setup register, bits taken on serial clock falling edges.
// - frame is 16 serial clocks; word in while previous result goes out.
// - word from a frame configures the next conversion, not current one.
// - only first 13 falling edges after select falls are captured.
// - bit 12 high loads the other 12 bits; low keeps register.
// - sequencer enable and shadow select together set sequencer and shadow access.
// - channel address and input mode apply at end of present conversion.
// - consecutive mode treats channel address as last channel of sequence.
// - channel address of a result shifts out before its 12 data bits.
// - input multiplexer switches channel on 14th falling edge.
// - bits 6 and 5 set power mode.
// - bit 3 picks weak drive of next address msb or high impedance idle.
// - bit 2 selects input range, four configurations with input mode.
// - bit 1 high straight binary, low two's complement.
// - bit 0 high single-ended, low differential pairs.
// - power 11 full power; bit 6 low auto shutdown with 1 us wake.
// - sequencer off with shadow select loads next write into shadow register.
module acrl_top (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic chip_select_n,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output logic serial_data_out_weak,
    input wire logic result_valid,
    output logic result_ready,
    input wire logic [11:0] result_data,
    output logic [3:0] mux_channel,
    output logic mux_differential,
    output logic range_select,
    output logic coding_straight,
    output logic [1:0] power_mode,
    output logic powered_down,
    output logic wake_ready,
    output logic sequencer_active,
    output logic [15:0] shadow_channels,
    output logic conversion_start
);
    logic cs_n_s;
    logic sck_s;
    logic din_s;
    logic cs_n_d_reg;
    logic sck_d_reg;
    logic [4:0] edge_cnt_reg;
    logic [12:0] shift_reg;
    logic [15:0] out_shift_reg;
    acrl_pkg::acrl_cfg_t cfg_reg;
    logic shadow_pend_reg;
    logic [3:0] chan_pick;
    logic [3:0] seq_chan_reg;
    logic [$clog2(acrl_pkg::WAKEUP_CYC + 1) - 1:0] wake_cnt_reg;
    logic cs_fall;
    logic cs_rise;
    logic sck_fall;
    logic in_frame;
    logic [3:0] result_chan_reg;
    logic buf_in_valid;
    logic buf_in_ready;
    acrl_pkg::acrl_result_t buf_in_data;
    logic buf_out_valid;
    acrl_pkg::acrl_result_t buf_out_data;

    acrl_sync u_sync_cs (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(chip_select_n), .q(cs_n_s));
    acrl_sync u_sync_sck (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(serial_clock), .q(sck_s));
    acrl_sync u_sync_din (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(serial_data_in), .q(din_s));

    assign cs_fall = cs_n_d_reg && !cs_n_s;
    assign cs_rise = !cs_n_d_reg && cs_n_s;
    assign sck_fall = sck_d_reg && !sck_s;
    assign in_frame = !cs_n_s;

    // decode of the sequencer mode from enable and shadow bits
    function automatic acrl_pkg::acrl_seq_t seq_decode(input logic seq_en, input logic shadow);
        case ({seq_en, shadow})
            2'b00: seq_decode = acrl_pkg::ACRL_SEQ_OFF;
            2'b01: seq_decode = acrl_pkg::ACRL_SEQ_SHADOW_LOAD;
            2'b10: seq_decode = acrl_pkg::ACRL_SEQ_CONSEC;
            2'b11: seq_decode = acrl_pkg::ACRL_SEQ_SHADOW_RUN;
            default: seq_decode = acrl_pkg::ACRL_SEQ_OFF;
        endcase
    endfunction

    // next channel of a running shadow sequence
    function automatic logic [3:0] shadow_next(input logic [15:0] mask, input logic [3:0] cur);
        logic [3:0] c;
        c = cur;
        shadow_next = cur;
        for (int i = 1; i <= 16; i++)
        begin
            c = 4'(cur + 4'(i));
            if (mask[c] && shadow_next == cur)
                shadow_next = c;
        end
    endfunction

    // edge detection state
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cs_n_d_reg <= 1'b1;
            sck_d_reg <= 1'b1;
        end
        else
        begin
            cs_n_d_reg <= cs_n_s;
            sck_d_reg <= sck_s;
        end
    end

    // falling edge counter within frame
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            edge_cnt_reg <= 5'h00;
        else if (cs_fall)
            edge_cnt_reg <= 5'h00;
        else if (in_frame && sck_fall && edge_cnt_reg != acrl_pkg::LAST_EDGE)
            edge_cnt_reg <= 5'(edge_cnt_reg + 5'h01);
    end

    // input shift, msb first
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            shift_reg <= 13'h0000;
        else if (in_frame && sck_fall && edge_cnt_reg < acrl_pkg::CAPTURE_EDGES)
            shift_reg <= {shift_reg[11:0], din_s};
    end

    // setup register and shadow load
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_reg <= acrl_pkg::CFG_RESET;
            shadow_pend_reg <= 1'b0;
            shadow_channels <= acrl_pkg::SHADOW_RESET;
        end
        else if (in_frame && sck_fall && edge_cnt_reg == 5'(acrl_pkg::CAPTURE_EDGES - 5'h01))
        begin
            if (shadow_pend_reg)
            begin
                shadow_channels <= {shift_reg[11:0], din_s, 3'h0};
                shadow_pend_reg <= 1'b0;
            end
            else if (shift_reg[11])
            begin
                cfg_reg <= {shift_reg[10:0], din_s};
                shadow_pend_reg <= !shift_reg[10] && shift_reg[3];
            end
        end
    end

    // channel for the next conversion, from the setup now in force
    always_comb
    begin
        chan_pick = cfg_reg.channel_address;
        case (seq_decode(cfg_reg.sequencer_enable, cfg_reg.shadow_select))
            acrl_pkg::ACRL_SEQ_CONSEC:
                chan_pick = seq_chan_reg >= cfg_reg.channel_address ? 4'h0
                    : 4'(seq_chan_reg + 4'h1);
            acrl_pkg::ACRL_SEQ_SHADOW_RUN:
                chan_pick = shadow_next(shadow_channels, seq_chan_reg);
            default:
                chan_pick = cfg_reg.channel_address;
        endcase
    end

    // sequencer position advanced at the 14th falling edge
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            seq_chan_reg <= 4'h0;
        else if (in_frame && sck_fall && edge_cnt_reg == 5'(acrl_pkg::MUX_EDGE - 5'h01))
            seq_chan_reg <= chan_pick;
    end

    // analog-side settings applied at end of present conversion
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mux_channel <= 4'h0;
            mux_differential <= 1'b0;
            range_select <= 1'b0;
            coding_straight <= 1'b1;
            power_mode <= acrl_pkg::PM_FULL;
            sequencer_active <= 1'b0;
        end
        else if (in_frame && sck_fall && edge_cnt_reg == 5'(acrl_pkg::MUX_EDGE - 5'h01))
        begin
            mux_channel <= chan_pick;
            mux_differential <= !cfg_reg.input_mode_select;
            range_select <= cfg_reg.range_select;
            coding_straight <= cfg_reg.coding_select;
            power_mode <= {cfg_reg.power_mode_hi, cfg_reg.power_mode_lo};
            sequencer_active <= cfg_reg.sequencer_enable;
        end
    end

    // auto shutdown and wake-up timing
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            powered_down <= 1'b0;
            wake_ready <= 1'b1;
            wake_cnt_reg <= '0;
        end
        else if (cs_rise && !power_mode[1])
        begin
            powered_down <= 1'b1;
            wake_ready <= 1'b0;
        end
        else if (cs_fall && powered_down)
        begin
            powered_down <= 1'b0;
            wake_cnt_reg <= ($bits(wake_cnt_reg))'(acrl_pkg::WAKEUP_CYC);
        end
        else if (wake_cnt_reg != '0)
        begin
            wake_cnt_reg <= ($bits(wake_cnt_reg))'(wake_cnt_reg - 1'b1);
            wake_ready <= wake_cnt_reg == ($bits(wake_cnt_reg))'(1);
        end
        else if (!powered_down)
            wake_ready <= 1'b1;
    end

    // conversion start pulse and result channel tag
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            conversion_start <= 1'b0;
            result_chan_reg <= 4'h0;
        end
        else
        begin
            conversion_start <= cs_fall;
            if (cs_fall)
                result_chan_reg <= mux_channel;
        end
    end

    assign buf_in_valid = result_valid;
    assign buf_in_data = '{channel: result_chan_reg, data: result_data};

    acrl_buf2 u_buf (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in_data),
        .out_valid(buf_out_valid),
        .out_ready(cs_fall),
        .out_data(buf_out_data)
    );

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            result_ready <= 1'b0;
        else
            result_ready <= buf_in_ready;
    end

    // output shifter: channel bits then 12 data bits
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_shift_reg <= 16'h0000;
            serial_data_out <= 1'b0;
            serial_data_out_oe <= 1'b0;
            serial_data_out_weak <= 1'b0;
        end
        else if (cs_fall)
        begin
            out_shift_reg <= buf_out_valid ? buf_out_data : 16'h0000;
            serial_data_out <= buf_out_valid ? buf_out_data.channel[3] : 1'b0;
            serial_data_out_oe <= 1'b1;
            serial_data_out_weak <= 1'b0;
        end
        else if (in_frame && sck_fall && edge_cnt_reg != acrl_pkg::LAST_EDGE)
        begin
            out_shift_reg <= {out_shift_reg[14:0], 1'b0};
            serial_data_out <= out_shift_reg[14];
            if (edge_cnt_reg == 5'(acrl_pkg::LAST_EDGE - 5'h01))
            begin
                serial_data_out <= cfg_reg.output_idle_select ? mux_channel[3] : 1'b0;
                serial_data_out_oe <= cfg_reg.output_idle_select;
                serial_data_out_weak <= cfg_reg.output_idle_select;
            end
        end
        else if (cs_rise)
        begin
            serial_data_out_oe <= cfg_reg.output_idle_select;
            serial_data_out_weak <= cfg_reg.output_idle_select;
            serial_data_out <= cfg_reg.output_idle_select ? mux_channel[3] : 1'b0;
        end
    end
endmodule

// ### verif/acrl_properties.sv
`timescale 1ns/10ps
module acrl_properties (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic chip_select_n,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe,
    input wire logic serial_data_out_weak,
    input wire logic [3:0] mux_channel,
    input wire logic range_select,
    input wire logic coding_straight,
    input wire logic [1:0] power_mode,
    input wire logic powered_down,
    input wire logic [15:0] shadow_channels,
    input wire logic conversion_start
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    sequence cs_fall;
        $fell(chip_select_n);
    endsequence
    sequence cs_idle;
        chip_select_n [*8];
    endsequence
    AST_START_PULSE: assert property (conversion_start |=> !conversion_start)
        else $error("start pulse too long");
    AST_START_AFTER_FALL: assert property (cs_fall |-> ##[2:4] conversion_start)
        else $error("no start after select fall");
    AST_START_CAUSE: assert property (conversion_start |-> $past(chip_select_n, 2) == 1'b0)
        else $error("start without select");
    AST_OE_IN_FRAME: assert property (cs_fall |-> ##[2:4] serial_data_out_oe)
        else $error("output not driven in frame");
    AST_SETTINGS_HOLD: assert property (cs_idle |-> $stable(mux_channel) && $stable(range_select)
        && $stable(coding_straight) && $stable(power_mode))
        else $error("settings moved outside frame");
    AST_SHADOW_HOLD: assert property (cs_idle |-> $stable(shadow_channels))
        else $error("shadow moved outside frame");
    AST_WEAK_NEEDS_OE: assert property (serial_data_out_weak |-> serial_data_out_oe)
        else $error("weak drive without enable");
    AST_IDLE_OE: assert property (cs_idle |-> serial_data_out_oe == serial_data_out_weak)
        else $error("idle output not weak or off");
    AST_WEAK_LEVEL: assert property (cs_idle ##0 serial_data_out_weak |-> serial_data_out == mux_channel[3])
        else $error("weak level not next address msb");
    AST_FULL_AWAKE: assert property ((power_mode == 2'h3) [*4] |-> !powered_down)
        else $error("powered down in full power");
endmodule
bind acrl_top acrl_properties i_props (.clk_sys, .sys_rst, .chip_select_n, .serial_data_out,
    .serial_data_out_oe, .serial_data_out_weak, .mux_channel, .range_select, .coding_straight,
    .power_mode, .powered_down, .shadow_channels, .conversion_start);

// ### verif/acrl_host_model.sv
`timescale 1ns/10ps
module acrl_host_model (
    output logic chip_select_n,
    output logic serial_clock,
    output logic serial_data_in,
    input wire logic serial_data_out,
    output logic [15:0] rx_word,
    output logic rx_done
);
    initial
    begin
        chip_select_n = 1'b1;
        serial_clock = 1'b1;
        serial_data_in = 1'b0;
        rx_word = 16'h0000;
        rx_done = 1'b0;
    end
    // clock idles high and stands still between frames
    task automatic frame(input logic [12:0] word, input int n);
        chip_select_n = 1'b0;
        rx_word = 16'h0000;
        #80;
        for (int i = 0; i < n; i++)
        begin
            serial_data_in = (i < 13) ? word[12 - i] : ~serial_data_in;
            #160;
            rx_word = {rx_word[14:0], serial_data_out};
            serial_clock = 1'b0;
            #160;
            serial_clock = 1'b1;
        end
        #160;
        chip_select_n = 1'b1;
        serial_data_in = ~serial_data_in;
        rx_done = 1'b1;
        #1 rx_done = 1'b0;
    endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic chip_select_n, serial_clock, serial_data_in;
    logic serial_data_out, serial_data_out_oe, serial_data_out_weak;
    logic result_valid = 1'b0;
    logic result_ready;
    logic [11:0] result_data = 12'h000;
    logic [3:0] mux_channel;
    logic [3:0] chan = 4'h0;
    logic [3:0] conv_chan = 4'h0;
    logic mux_differential, range_select, coding_straight;
    logic [1:0] power_mode;
    logic powered_down, wake_ready, sequencer_active, conversion_start, rx_done;
    logic [15:0] shadow_channels, rx_word;
    logic [31:0] seed = 32'h0000E0F6;
    logic [11:0] cfg = 12'hFE3;
    logic [15:0] exp_q[$];
    logic [15:0] res_q[$];
    int n_errors = 0;
    int compares = 0;
    always #20 clk_sys = ~clk_sys;
    acrl_top i_dut (.clk_sys, .sys_rst, .chip_select_n, .serial_clock, .serial_data_in,
        .serial_data_out, .serial_data_out_oe, .serial_data_out_weak, .result_valid,
        .result_ready, .result_data, .mux_channel, .mux_differential, .range_select,
        .coding_straight, .power_mode, .powered_down, .wake_ready, .sequencer_active,
        .shadow_channels, .conversion_start);
    acrl_host_model i_host (.chip_select_n, .serial_clock, .serial_data_in,
        .serial_data_out, .rx_word, .rx_done);
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic push(input logic [11:0] d);
        int k;
        k = 0;
        while (result_ready !== 1'b1 && k < 50)
        begin
            @(negedge clk_sys);
            k++;
        end
        if (k == 50)
        begin
            check("result_ready wait", 16'h0001, {15'h0000, result_ready});
            summarize();
        end
        result_valid = 1'b1;
        result_data = d;
        @(negedge clk_sys);
        result_valid = 1'b0;
        res_q.push_back({conv_chan, d});
        repeat (2) @(negedge clk_sys);
    endtask
    // a result carries the channel of the conversion begun at the select fall before it
    task automatic frame(input logic [12:0] w, input int n, input logic upd);
        logic [15:0] e;
        e = res_q.pop_front();
        exp_q.push_back(e >> (16 - n));
        i_host.frame(w, n);
        conv_chan = chan;
        if (upd)
        begin
            cfg = w[11:0];
            chan = w[10:7];
        end
        repeat (12) @(negedge clk_sys);
    endtask
    task automatic check_cfg;
        check("mux_channel", {12'h000, cfg[10:7]}, {12'h000, mux_channel});
        check("mux_differential", {15'h0000, ~cfg[0]}, {15'h0000, mux_differential});
        check("range_select", {15'h0000, cfg[2]}, {15'h0000, range_select});
        check("coding_straight", {15'h0000, cfg[1]}, {15'h0000, coding_straight});
        check("power_mode", {14'h0000, cfg[6:5]}, {14'h0000, power_mode});
        check("sequencer_active", {15'h0000, cfg[11]}, {15'h0000, sequencer_active});
        check("dout_oe", {15'h0000, cfg[3]}, {15'h0000, serial_data_out_oe});
        check("powered_down", {15'h0000, ~cfg[6]}, {15'h0000, powered_down});
        check("wake_ready", {15'h0000, cfg[6]}, {15'h0000, wake_ready});
    endtask
    initial
    begin
        forever
        begin
            @(posedge rx_done);
            if (exp_q.size() == 0)
                check("frame note", 16'h0001, 16'h0000);
            else
                check("serial_data_out", exp_q.pop_front(), rx_word);
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("reset power", 16'h0003, {14'h0000, power_mode});
        check("reset coding", 16'h0001, {15'h0000, coding_straight});
        check("reset wake", 16'h0001, {15'h0000, wake_ready});
        $display("test reset done");
        for (int i = 0; i < 10; i++)
        begin
            seed = xs(seed);
            push(seed[27:16]);
            frame({2'b10, seed[10:5], 1'b0, seed[3:0]}, 16, 1'b1);
            check_cfg();
        end
        $display("test random writes done");
        push(12'hA5C);
        frame({1'b1, ~cfg}, 8, 1'b0);
        push(12'h3C1);
        frame({1'b0, ~cfg}, 16, 1'b0);
        check_cfg();
        $display("test hold done");
        push(12'h111);
        push(12'h222);
        check("result_ready full", 16'h0000, {15'h0000, result_ready});
        for (int i = 0; i < 2; i++)
        begin
            seed = xs(seed);
            frame({2'b10, seed[10:5], 1'b0, seed[3:0]}, 16, 1'b1);
            check_cfg();
        end
        check("result_ready drained", 16'h0001, {15'h0000, result_ready});
        $display("test buffer done");
        push(12'h5A5);
        frame({2'b10, cfg[10:5], 1'b1, 1'b0, cfg[2:0]}, 16, 1'b0);
        seed = xs(seed);
        push(12'h0F0);
        frame(seed[12:0], 16, 1'b0);
        check("shadow_channels", {3'h0, seed[12:0]}, {3'h0, shadow_channels[15:3]});
        $display("test shadow done");
        push(12'h0C3);
        frame({2'b11, 4'h2, 2'b11, 5'h03}, 16, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            chan = chan >= 4'h2 ? 4'h0 : 4'(chan + 4'h1);
            check("consec channel", {12'h000, chan}, {12'h000, mux_channel});
            push(12'h0C3);
            frame(13'h0000, 16, 1'b0);
        end
        $display("test consecutive done");
        summarize();
    end
endmodule
